// ---- hdl/ffi_map.svh ----
// Purpose: offsets, bit positions and reset values of the fault flag block
// Assumes: 8-bit registers on the device register port
// Notes:   definitions only
`ifndef FFI_MAP_SVH
`define FFI_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define FFI_OFS_SEVERE 8'h68
`define FFI_OFS_SEQ    8'h69
`define FFI_OFS_COMM   8'h6A
// ----------------------------------------
// reset values and clearable bit masks
// ----------------------------------------
`define FFI_RST_SEVERE 8'h00
`define FFI_RST_SEQ    8'h00
`define FFI_RST_COMM   8'h00
`define FFI_W1C_SEVERE 8'h07
`define FFI_W1C_SEQ    8'h0F
`define FFI_W1C_COMM   8'hAB
// ----------------------------------------
// field positions
// ----------------------------------------
`define FFI_SEV_SEQERR 2
`define FFI_SEV_OVP    1
`define FFI_SEV_TSD    0
`define FFI_SEQ_WD     7
`define FFI_SEQ_ESM    6
`define FFI_SEQ_RDBK   5
`define FFI_SEQ_COMM   4
`define FFI_SEQ_SOC    3
`define FFI_SEQ_MCU    2
`define FFI_SEQ_ORD    1
`define FFI_SEQ_IMM    0
`define FFI_COM_P2ADR  7
`define FFI_COM_P2CRC  5
`define FFI_COM_P1ADR  3
`define FFI_COM_P1CRC  1
`define FFI_COM_FRM    0
`endif

// ---- hdl/ffi_pkg.sv ----
// Purpose: types of the fault flag block
// Assumes: nothing
// Notes:   offsets live in ffi_map.svh
package ffi_pkg;
   typedef logic [7:0] ffi_byte_t;
   typedef struct packed {
      ffi_byte_t flags;
   } ffi_bank_s;
   typedef struct packed {
      ffi_byte_t data;
      logic      valid;
   } ffi_rd_s;
   typedef struct packed {
      logic tsdPrev;
      logic ovpPrev;
      logic offPulse;
      logic live;
      logic irqN;
   } ffi_top_s;
endpackage

// ---- hdl/ffi_w1c_bank.sv ----
// Purpose: one 8-bit bank of latched flags, cleared by writing one
// Assumes: sys_rst synchronous, active high
// Notes:   bits outside IMPL stay zero
`timescale 1ns/1ps
`default_nettype none
module ffi_w1c_bank
   import ffi_pkg::*;
#(
   parameter ffi_byte_t IMPL  = 8'hFF,
   parameter ffi_byte_t RSTV  = 8'h00
)
(
   input  wire logic      clk,
   input  wire logic      sys_rst,
   input  wire ffi_byte_t setVec,
   input  wire ffi_byte_t clrVec,
   output ffi_byte_t      flags
);
   ffi_bank_s state_ff;
   ffi_bank_s nxt_state;

   if (IMPL == 8'h00 || (RSTV & ~IMPL) != 8'h00)
      $error("ffi_w1c_bank: bad IMPL or RSTV");

   // set beats a clear landing in the same cycle, so no event is lost
   always_comb
   begin
      nxt_state = state_ff;
      for (int i = 0; i < 8; i++)
      begin
         nxt_state.flags[i] = IMPL[i] & (setVec[i] | (state_ff.flags[i] & ~clrVec[i]));
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state_ff <= '{flags: RSTV};
      else
         state_ff <= nxt_state;
   end

   assign flags = state_ff.flags;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   set_wins_a: assert property ((setVec & IMPL) != 8'h00 |=>
      (flags & $past(setVec) & IMPL) == ($past(setVec) & IMPL))
      else $error("set event lost");
   clr_one_a: assert property ((flags & clrVec & ~setVec) != 8'h00 |=> (flags & $past(clrVec) & ~$past(setVec)) == 8'h00)
      else $error("write one did not clear");
   hold_a: assert property (setVec == 8'h00 && clrVec == 8'h00 |=> $stable(flags))
      else $error("flag changed without cause");
   rsvd_zero_a: assert property ((flags & ~IMPL) == 8'h00)
      else $error("reserved bit set");
endmodule
`default_nettype wire

// ---- hdl/ffi_rd_port.sv ----
// Purpose: registered read of the three flag registers
// Assumes: one read request per cycle at most
// Notes:   unmapped offsets read zero
`timescale 1ns/1ps
`default_nettype none
`include "ffi_map.svh"
module ffi_rd_port
   import ffi_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      sys_rst,
   input  wire logic      rdEn,
   input  wire ffi_byte_t addr,
   input  wire ffi_byte_t severe,
   input  wire ffi_byte_t seq,
   input  wire ffi_byte_t comm,
   output ffi_byte_t      rdData,
   output logic           rdValid
);
   ffi_rd_s state_ff;
   ffi_rd_s nxt_state;

   always_comb
   begin
      nxt_state.valid = rdEn;
      nxt_state.data  = state_ff.data;
      if (rdEn)
      begin
         case (addr)
            `FFI_OFS_SEVERE: nxt_state.data = severe;
            `FFI_OFS_SEQ:    nxt_state.data = seq;
            `FFI_OFS_COMM:   nxt_state.data = comm;
            default:         nxt_state.data = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state_ff <= '0;
      else
         state_ff <= nxt_state;
   end

   assign rdData  = state_ff.data;
   assign rdValid = state_ff.valid;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   rd_answer_a: assert property (rdEn && addr == `FFI_OFS_SEQ |=> rdValid && rdData == $past(seq))
      else $error("read answer wrong");
   rd_unmapped_a: assert property (rdEn && addr != `FFI_OFS_SEVERE && addr != `FFI_OFS_SEQ
      && addr != `FFI_OFS_COMM |=> rdValid && rdData == 8'h00)
      else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ---- hdl/ffi_top.sv ----
// Purpose: latched fault and interrupt flags with active-low interrupt
// Assumes: events are one-cycle pulses, levels are synchronous to clk
// Notes:   source registers of summary bits 7, 6 and 5 sit outside this block
`timescale 1ns/1ps
`default_nettype none
`include "ffi_map.svh"
//
// Contract
// - sequencer error sets severe bit 2, held until cleared.
// - supply overvoltage: immediate shutdown, regulators off, severe bit 1 set.
// - thermal trip: regulators off, severe bit 0 set, enables refused while set.
// - live thermal state shown apart from the latched flag.
// - a latched flag stays until one is written to its bit.
// - summary bit 7 shows pending watchdog reset, fail or long-window flags.
// - summary bit 6 shows error monitor register nonzero.
// - summary bit 5 shows readback register nonzero.
// - summary bit 4 shows communication register nonzero.
// - system-on-chip rail error sets sequencer bit 3.
// - microcontroller rail error sets sequencer bit 2.
// - orderly shutdown sets sequencer bit 1.
// - immediate shutdown sets sequencer bit 0.
// - secondary port bad write address sets communication bit 7.
// - secondary port check failure sets communication bit 5.
// - secondary port errors interrupt only if check enabled and unmasked.
// - primary port bad write address sets communication bit 3.
// - primary port check failure sets communication bit 1.
// - primary port errors interrupt only if check enabled and unmasked.
// - malformed serial frame sets communication bit 0.
module ffi_top
   import ffi_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      sys_rst,
   // register port
   input  wire logic      regWrEn,
   input  wire logic      regRdEn,
   input  wire ffi_byte_t regAddr,
   input  wire ffi_byte_t regWrData,
   output ffi_byte_t      regRdData,
   output logic           regRdValid,
   // fault sources
   input  wire logic      sequencerErrEvt,
   input  wire logic      supplyOverLevel,
   input  wire logic      thermalHotLevel,
   input  wire logic      socRailErrEvt,
   input  wire logic      mcuRailErrEvt,
   input  wire logic      orderlyOffEvt,
   input  wire logic      immediateOffEvt,
   input  wire logic      secondPortAddrEvt,
   input  wire logic      secondPortCheckEvt,
   input  wire logic      primaryPortAddrEvt,
   input  wire logic      primaryPortCheckEvt,
   input  wire logic      spiFrameErrEvt,
   // summary sources
   input  wire logic [2:0] watchdogFlags,
   input  wire ffi_byte_t errorMonitorFlags,
   input  wire ffi_byte_t outputCheckFlags,
   // port check controls
   input  wire logic      secondPortCheckEnable,
   input  wire logic      secondPortCheckMask,
   input  wire logic      primaryPortCheckEnable,
   input  wire logic      primaryPortCheckMask,
   // regulator control, thermal status and interrupt
   input  wire logic      regEnableReq,
   output logic           regEnableGrant,
   output logic           regulatorsOff,
   output logic           thermalImmediateLive,
   output logic           irqOutN
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   ffi_top_s  state_ff;
   ffi_top_s  nxt_state;
   ffi_byte_t severeFlags;
   ffi_byte_t seqFlags;
   ffi_byte_t commFlags;
   ffi_byte_t seqView;
   ffi_byte_t severeSet;
   ffi_byte_t seqSet;
   ffi_byte_t commSet;
   ffi_byte_t severeClr;
   ffi_byte_t seqClr;
   ffi_byte_t commClr;
   logic      tsdRise;
   logic      ovpRise;
   logic      immShut;
   logic      secondGate;
   logic      primaryGate;
   ffi_byte_t commGated;
   logic      anyPending;

   // ----------------------------------------
   // event detection
   // ----------------------------------------
   // edges, not levels: a lingering condition must not re-set a cleared flag
   assign tsdRise = thermalHotLevel & ~state_ff.tsdPrev;
   assign ovpRise = supplyOverLevel & ~state_ff.ovpPrev;
   assign immShut = tsdRise | ovpRise | immediateOffEvt;

   always_comb
   begin
      severeSet = 8'h00;
      severeSet[`FFI_SEV_SEQERR] = sequencerErrEvt;
      severeSet[`FFI_SEV_OVP]    = ovpRise;
      severeSet[`FFI_SEV_TSD]    = tsdRise;
   end

   always_comb
   begin
      seqSet = 8'h00;
      seqSet[`FFI_SEQ_SOC] = socRailErrEvt;
      seqSet[`FFI_SEQ_MCU] = mcuRailErrEvt;
      seqSet[`FFI_SEQ_ORD] = orderlyOffEvt;
      seqSet[`FFI_SEQ_IMM] = immShut;
   end

   always_comb
   begin
      commSet = 8'h00;
      commSet[`FFI_COM_P2ADR] = secondPortAddrEvt;
      commSet[`FFI_COM_P2CRC] = secondPortCheckEvt;
      commSet[`FFI_COM_P1ADR] = primaryPortAddrEvt;
      commSet[`FFI_COM_P1CRC] = primaryPortCheckEvt;
      commSet[`FFI_COM_FRM]   = spiFrameErrEvt;
   end

   // ----------------------------------------
   // write one to clear
   // ----------------------------------------
   // reserved bits are dropped by the banks, so writes there do nothing
   assign severeClr = (regWrEn && regAddr == `FFI_OFS_SEVERE) ? regWrData : 8'h00;
   assign seqClr    = (regWrEn && regAddr == `FFI_OFS_SEQ)    ? regWrData : 8'h00;
   assign commClr   = (regWrEn && regAddr == `FFI_OFS_COMM)   ? regWrData : 8'h00;

   ffi_w1c_bank #(
      .IMPL (`FFI_W1C_SEVERE),
      .RSTV (`FFI_RST_SEVERE)
   ) severeBank (
      .clk     (clk),
      .sys_rst (sys_rst),
      .setVec  (severeSet),
      .clrVec  (severeClr),
      .flags   (severeFlags)
   );

   ffi_w1c_bank #(
      .IMPL (`FFI_W1C_SEQ),
      .RSTV (`FFI_RST_SEQ)
   ) seqBank (
      .clk     (clk),
      .sys_rst (sys_rst),
      .setVec  (seqSet),
      .clrVec  (seqClr),
      .flags   (seqFlags)
   );

   ffi_w1c_bank #(
      .IMPL (`FFI_W1C_COMM),
      .RSTV (`FFI_RST_COMM)
   ) commBank (
      .clk     (clk),
      .sys_rst (sys_rst),
      .setVec  (commSet),
      .clrVec  (commClr),
      .flags   (commFlags)
   );

   // ----------------------------------------
   // summary bits
   // ----------------------------------------
   // read-only, follow their sources with no latch of their own
   always_comb
   begin
      seqView = seqFlags;
      seqView[`FFI_SEQ_WD]   = |watchdogFlags;
      seqView[`FFI_SEQ_ESM]  = |errorMonitorFlags;
      seqView[`FFI_SEQ_RDBK] = |outputCheckFlags;
      seqView[`FFI_SEQ_COMM] = |commFlags;
   end

   ffi_rd_port rdPort (
      .clk     (clk),
      .sys_rst (sys_rst),
      .rdEn    (regRdEn),
      .addr    (regAddr),
      .severe  (severeFlags),
      .seq     (seqView),
      .comm    (commFlags),
      .rdData  (regRdData),
      .rdValid (regRdValid)
   );

   // ----------------------------------------
   // interrupt
   // ----------------------------------------
   assign secondGate  = secondPortCheckEnable & ~secondPortCheckMask;
   assign primaryGate = primaryPortCheckEnable & ~primaryPortCheckMask;

   always_comb
   begin
      commGated = commFlags;
      commGated[`FFI_COM_P2ADR] = commFlags[`FFI_COM_P2ADR] & secondGate;
      commGated[`FFI_COM_P2CRC] = commFlags[`FFI_COM_P2CRC] & secondGate;
      commGated[`FFI_COM_P1ADR] = commFlags[`FFI_COM_P1ADR] & primaryGate;
      commGated[`FFI_COM_P1CRC] = commFlags[`FFI_COM_P1CRC] & primaryGate;
   end

   // comm summary bit is left out: its sources are already gated above
   assign anyPending = (|severeFlags) | (|seqFlags) | (|commGated)
                     | seqView[`FFI_SEQ_WD] | seqView[`FFI_SEQ_ESM]
                     | seqView[`FFI_SEQ_RDBK];

   // ----------------------------------------
   // registered outputs, and the unregistered enable grant
   // ----------------------------------------
   always_comb
   begin
      nxt_state          = state_ff;
      nxt_state.tsdPrev  = thermalHotLevel;
      nxt_state.ovpPrev  = supplyOverLevel;
      nxt_state.offPulse = tsdRise | ovpRise;
      nxt_state.live     = thermalHotLevel;
      nxt_state.irqN     = ~anyPending;
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
         state_ff <= '{tsdPrev: 1'b0, ovpPrev: 1'b0, offPulse: 1'b0,
                       live: 1'b0, irqN: 1'b1};
      else
         state_ff <= nxt_state;
   end

   assign regulatorsOff        = state_ff.offPulse;
   assign thermalImmediateLive = state_ff.live;
   assign irqOutN              = state_ff.irqN;
   // enable refused for as long as the thermal flag is latched
   assign regEnableGrant = regEnableReq & ~severeFlags[`FFI_SEV_TSD];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence ovpEdge_s;
      !supplyOverLevel ##1 supplyOverLevel;
   endsequence
   sequence offSeen_s;
      regulatorsOff && severeFlags[`FFI_SEV_OVP] && seqFlags[`FFI_SEQ_IMM];
   endsequence

   seq_err_latch_a: assert property (sequencerErrEvt |=> severeFlags[`FFI_SEV_SEQERR])
      else $error("sequencer error not latched");
   ovp_shutdown_a: assert property (ovpEdge_s |=> offSeen_s)
      else $error("overvoltage shutdown missing");
   tsd_refuse_a: assert property (severeFlags[`FFI_SEV_TSD] |-> !regEnableGrant)
      else $error("enable granted during thermal flag");
   live_follow_a: assert property (##1 thermalImmediateLive == $past(thermalHotLevel))
      else $error("live thermal status wrong");
   wd_summary_a: assert property (watchdogFlags != 3'h0 |-> seqView[`FFI_SEQ_WD])
      else $error("watchdog summary missing");
   esm_summary_a: assert property (seqView[`FFI_SEQ_ESM] == (errorMonitorFlags != 8'h00))
      else $error("monitor summary wrong");
   rdbk_summary_a: assert property (seqView[`FFI_SEQ_RDBK] == (outputCheckFlags != 8'h00))
      else $error("readback summary wrong");
   comm_summary_a: assert property (seqView[`FFI_SEQ_COMM] == (commFlags != 8'h00))
      else $error("comm summary wrong");
   rail_latch_a: assert property (socRailErrEvt || mcuRailErrEvt |=>
      (seqFlags[3:2] & $past({socRailErrEvt, mcuRailErrEvt}))
      == $past({socRailErrEvt, mcuRailErrEvt}))
      else $error("rail error not latched");
   orderly_latch_a: assert property (orderlyOffEvt |=> seqFlags[`FFI_SEQ_ORD])
      else $error("orderly shutdown not latched");
   imm_latch_a: assert property (tsdRise |=> seqFlags[`FFI_SEQ_IMM] [*1] ##0 regulatorsOff)
      else $error("immediate shutdown not latched");
   second_mask_a: assert property (!secondGate && (commFlags & 8'h5F) == 8'h00 && severeFlags == 8'h00 && seqFlags == 8'h00 && !seqView[7] && !seqView[6] && !seqView[5] |=> irqOutN)
      else $error("masked secondary error raised interrupt");
   primary_irq_a: assert property (primaryGate && commFlags[`FFI_COM_P1CRC] |=> !irqOutN)
      else $error("primary error did not interrupt");
   frame_irq_a: assert property (spiFrameErrEvt |=> commFlags[`FFI_COM_FRM] ##1 !irqOutN)
      else $error("frame error did not interrupt");
   addr_latch_a: assert property (secondPortAddrEvt || primaryPortAddrEvt |=>
      ({commFlags[7], commFlags[3]} & $past({secondPortAddrEvt, primaryPortAddrEvt}))
      == $past({secondPortAddrEvt, primaryPortAddrEvt}))
      else $error("address error not latched");
   crc2_latch_a: assert property (secondPortCheckEvt |=> commFlags[`FFI_COM_P2CRC])
      else $error("secondary check error not latched");
endmodule
`default_nettype wire

// ---- dv/ffi_host_model.sv ----
// Purpose: host side of the register port, reads and clears flags
// Assumes: one request at a time, strobes driven by NBA at rising edge
// Notes:   clears only by writing ones, never by read
`timescale 1ns/1ps
`default_nettype none
module ffi_host_model
   import ffi_pkg::*;
(
   input  wire logic      clk,
   input  wire ffi_byte_t regRdData,
   input  wire logic      regRdValid,
   output logic           regWrEn,
   output logic           regRdEn,
   output ffi_byte_t      regAddr,
   output ffi_byte_t      regWrData
);
   initial
   begin
      regWrEn   = 1'b0;
      regRdEn   = 1'b0;
      regAddr   = 8'h00;
      regWrData = 8'h00;
   end
   // ----------------------------------------
   // bus cycles
   // ----------------------------------------
   // a one in the data is the only way to clear
   task automatic wr(input ffi_byte_t a, input ffi_byte_t d);
      @(posedge clk);
      regWrEn   <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge clk);
      regWrEn   <= 1'b0;
   endtask
   // answer sampled mid-cycle, clear of the edge race
   task automatic rd(input ffi_byte_t a, output ffi_byte_t d, output logic v);
      @(posedge clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRdEn <= 1'b0;
      @(negedge clk);
      v = regRdValid;
      d = regRdData;
   endtask
endmodule
`default_nettype wire

// ---- dv/fault_interrupt_flags_tb_top.sv ----
// Purpose: self-checking bench of the fault flag block
// Assumes: 125 MHz clock, synchronous active-high reset
// Notes:   event rows first, awkward cases after
`timescale 1ns/1ps
`default_nettype none
`include "ffi_map.svh"
module fault_interrupt_flags_tb_top
   import ffi_pkg::*;
;
   typedef struct packed {
      logic [3:0] idx;
      ffi_byte_t  sev;
      ffi_byte_t  seq;
      ffi_byte_t  com;
   } ffi_row_s;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic       clk;
   logic       sysRst;
   logic [11:0] evt;
   logic [2:0] watchdogFlags;
   ffi_byte_t  errorMonitorFlags;
   ffi_byte_t  outputCheckFlags;
   logic       secEn;
   logic       secMask;
   logic       priEn;
   logic       priMask;
   logic       regEnableReq;
   logic       regWrEn;
   logic       regRdEn;
   ffi_byte_t  regAddr;
   ffi_byte_t  regWrData;
   ffi_byte_t  regRdData;
   logic       regRdValid;
   logic       regEnableGrant;
   logic       regulatorsOff;
   logic       thermalImmediateLive;
   logic       irqOutN;
   int         nErrors;
   int         nChecks;
   int         cycles = 0;
   ffi_row_s   rows [12] = '{
      '{4'h0, 8'h04, 8'h00, 8'h00},
      '{4'h1, 8'h02, 8'h01, 8'h00},
      '{4'h2, 8'h01, 8'h01, 8'h00},
      '{4'h3, 8'h00, 8'h08, 8'h00},
      '{4'h4, 8'h00, 8'h04, 8'h00},
      '{4'h5, 8'h00, 8'h02, 8'h00},
      '{4'h6, 8'h00, 8'h01, 8'h00},
      '{4'h7, 8'h00, 8'h10, 8'h80},
      '{4'h8, 8'h00, 8'h10, 8'h20},
      '{4'h9, 8'h00, 8'h10, 8'h08},
      '{4'hA, 8'h00, 8'h10, 8'h02},
      '{4'hB, 8'h00, 8'h10, 8'h01}};
   // ----------------------------------------
   // design and host
   // ----------------------------------------
   ffi_top DUT (
      .clk(clk), .sys_rst(sysRst), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
      .regRdValid(regRdValid), .sequencerErrEvt(evt[0]), .supplyOverLevel(evt[1]),
      .thermalHotLevel(evt[2]), .socRailErrEvt(evt[3]), .mcuRailErrEvt(evt[4]),
      .orderlyOffEvt(evt[5]), .immediateOffEvt(evt[6]), .secondPortAddrEvt(evt[7]),
      .secondPortCheckEvt(evt[8]), .primaryPortAddrEvt(evt[9]),
      .primaryPortCheckEvt(evt[10]), .spiFrameErrEvt(evt[11]),
      .watchdogFlags(watchdogFlags), .errorMonitorFlags(errorMonitorFlags),
      .outputCheckFlags(outputCheckFlags), .secondPortCheckEnable(secEn),
      .secondPortCheckMask(secMask), .primaryPortCheckEnable(priEn),
      .primaryPortCheckMask(priMask), .regEnableReq(regEnableReq),
      .regEnableGrant(regEnableGrant), .regulatorsOff(regulatorsOff),
      .thermalImmediateLive(thermalImmediateLive), .irqOutN(irqOutN));
   ffi_host_model host (
      .clk(clk), .regRdData(regRdData), .regRdValid(regRdValid), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData));
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   always #4 clk = ~clk;
   task automatic conclude();
      if (nErrors == 0 && nChecks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // hang guard, whole run is well under a thousand cycles
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         nErrors++;
         conclude();
      end
   end
   task automatic chk(input ffi_byte_t got, input ffi_byte_t exp);
      nChecks++;
      if (got !== exp)
      begin
         nErrors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rdChk(input ffi_byte_t a, input ffi_byte_t exp);
      ffi_byte_t d;
      logic      v;
      host.rd(a, d, v);
      chk({7'h00, v}, 8'h01);
      chk(d, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   task automatic pulse(input int i);
      @(posedge clk);
      evt <= 12'h001 << i;
      @(posedge clk);
      evt <= 12'h000;
   endtask
   task automatic clrAll();
      host.wr(`FFI_OFS_SEVERE, 8'hFF);
      host.wr(`FFI_OFS_SEQ, 8'hFF);
      host.wr(`FFI_OFS_COMM, 8'hFF);
      settle(2);
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      clk = 1'b0;
      sysRst = 1'b1;
      evt = 12'h000;
      watchdogFlags = 3'h0;
      errorMonitorFlags = 8'h00;
      outputCheckFlags = 8'h00;
      secEn = 1'b1;
      secMask = 1'b0;
      priEn = 1'b1;
      priMask = 1'b0;
      regEnableReq = 1'b1;
      nErrors = 0;
      nChecks = 0;
      repeat (10) @(posedge clk);
      sysRst <= 1'b0;
      for (int i = 0; i < 12; i++)
      begin
         pulse(rows[i].idx);
         settle(2);
         chk({7'h00, irqOutN}, 8'h00);
         rdChk(`FFI_OFS_SEVERE, rows[i].sev);
         rdChk(`FFI_OFS_SEQ, rows[i].seq);
         rdChk(`FFI_OFS_COMM, rows[i].com);
         clrAll();
         chk({7'h00, irqOutN}, 8'h01);
         rdChk(`FFI_OFS_SEQ, 8'h00);
      end
      // thermal level held: live copy stays, latched bit clears, enables refused until the clear
      @(posedge clk);
      evt <= 12'h004;
      settle(0);
      chk({7'h00, regulatorsOff}, 8'h00);
      settle(0);
      chk({6'h00, regulatorsOff, regEnableGrant}, 8'h02);
      settle(0);
      chk({7'h00, regulatorsOff}, 8'h00);
      clrAll();
      rdChk(`FFI_OFS_SEVERE, 8'h00);
      chk({6'h00, thermalImmediateLive, regEnableGrant}, 8'h03);
      @(posedge clk);
      evt <= 12'h000;
      settle(2);
      chk({7'h00, thermalImmediateLive}, 8'h00);
      // port check gating: disabled, masked, both
      for (int p = 0; p < 2; p++)
         for (int c = 0; c < 3; c++)
         begin
            @(posedge clk);
            secEn <= c[0];
            priEn <= c[0];
            secMask <= (c != 0);
            priMask <= (c != 0);
            pulse(p ? 10 : 8);
            settle(3);
            chk({7'h00, irqOutN}, 8'h01);
            rdChk(`FFI_OFS_COMM, p ? 8'h02 : 8'h20);
            clrAll();
         end
      @(posedge clk);
      secEn <= 1'b1;
      priEn <= 1'b1;
      secMask <= 1'b0;
      priMask <= 1'b0;
      // summary bits follow their outside registers
      for (int k = 0; k < 5; k++)
      begin
         @(posedge clk);
         watchdogFlags <= (k < 3) ? (3'h1 << k) : 3'h0;
         errorMonitorFlags <= (k == 3) ? 8'h20 : 8'h00;
         outputCheckFlags <= (k == 4) ? 8'h08 : 8'h00;
         settle(3);
         chk({7'h00, irqOutN}, 8'h00);
         rdChk(`FFI_OFS_SEQ, (k < 3) ? 8'h80 : (k == 3) ? 8'h40 : 8'h20);
         host.wr(`FFI_OFS_SEQ, 8'hF0);
         rdChk(`FFI_OFS_SEQ, (k < 3) ? 8'h80 : (k == 3) ? 8'h40 : 8'h20);
         @(posedge clk);
         watchdogFlags <= 3'h0;
         errorMonitorFlags <= 8'h00;
         outputCheckFlags <= 8'h00;
         settle(3);
         chk({7'h00, irqOutN}, 8'h01);
         rdChk(`FFI_OFS_SEQ, 8'h00);
      end
      // reserved and zero writes leave a latched flag alone
      pulse(7);
      host.wr(`FFI_OFS_COMM, 8'h54);
      rdChk(`FFI_OFS_COMM, 8'h80);
      host.wr(`FFI_OFS_COMM, 8'h00);
      rdChk(`FFI_OFS_COMM, 8'h80);
      host.wr(`FFI_OFS_COMM, 8'h80);
      rdChk(`FFI_OFS_COMM, 8'h00);
      // mid-run reset with flags pending, unmapped offset reads zero
      pulse(0);
      pulse(11);
      @(posedge clk);
      sysRst <= 1'b1;
      @(posedge clk);
      sysRst <= 1'b0;
      settle(1);
      chk({7'h00, irqOutN}, 8'h01);
      for (int a = 0; a < 4; a++)
         rdChk(8'h68 + a[7:0], 8'h00);
      conclude();
   end
endmodule
`default_nettype wire
